// ==== design/bcx_pkg.sv ====
package bcx_pkg;

    // quarter phases of one instruction cycle
    typedef enum logic [1:0] {
        BCX_Q1,
        BCX_Q2,
        BCX_Q3,
        BCX_Q4
    } bcx_phase_t;

    typedef enum logic [3:0] {
        BCX_OP_OTHER,
        BCX_OP_SKIP_BIT,
        BCX_OP_TOGGLE,
        BCX_OP_CALL,
        BCX_OP_CLEAR,
        BCX_OP_WDOG_CLR,
        BCX_OP_COMP,
        BCX_OP_SKIP_EQ,
        BCX_OP_SKIP_GT
    } bcx_op_t;

    // opcode patterns, compared against the top bits of the word
    localparam logic [4:0]  OPC_SKIP_BIT = 5'h12;
    localparam logic [4:0]  OPC_TOGGLE   = 5'h07;
    localparam logic [2:0]  OPC_CALL     = 3'h7;
    localparam logic [6:0]  OPC_CLEAR    = 7'h14;
    localparam logic [6:0]  OPC_COMP     = 7'h09;
    localparam logic [7:0]  OPC_SKIP_EQ  = 8'h31;
    localparam logic [7:0]  OPC_SKIP_GT  = 8'h32;
    localparam logic [15:0] OPC_WDOG_CLR = 16'h0004;

    // field positions inside the instruction word
    localparam int unsigned BIT_SEL_LSB  = 8;
    localparam int unsigned DEST_BIT     = 8;
    localparam int unsigned CALL_LIT_MSB = 12;

    // register map, byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_WORK   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PC_HIGH = 8'h0C;

    // reset values
    localparam logic       RST_EXEC_EN = 1'b1;
    localparam logic [7:0] RST_WORK    = 8'h00;
    localparam logic [7:0] RST_PC_HIGH = 8'h00;
    localparam logic       RST_FLAG_N  = 1'b1;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bcx_dmem_req_t;

    typedef struct packed {
        logic        load;
        logic [15:0] target;
        logic        push;
        logic [15:0] ret_addr;
    } bcx_pc_req_t;

endpackage

// ==== design/bcx_exec.sv ====
module bcx_exec (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   clk_en,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // fetch side
    input  wire logic [15:0]            instr_word,
    input  wire logic [15:0]            pc_cur,
    output logic                        squash_fetch,
    output bcx_pkg::bcx_phase_t         phase,
    // data memory
    output bcx_pkg::bcx_dmem_req_t      dmem,
    input  wire logic [7:0]             dmem_rdata,
    // program counter and stack
    output bcx_pkg::bcx_pc_req_t        pc_req,
    output logic      [7:0]             pc_high_latch,
    // working register and status
    output logic      [7:0]             working_reg,
    output logic                        zero_flag,
    output logic                        timeout_flag_n,
    output logic                        powerdown_flag_n,
    // watchdog
    input  wire logic                   wdt_timeout_evt,
    input  wire logic                   sleep_evt,
    output logic                        wdt_clr,
    output logic                        wdt_post_clr
);
    import bcx_pkg::*;

    function automatic bcx_op_t bcx_decode(input logic [15:0] w);
        bcx_op_t r;
        r = BCX_OP_OTHER;
        if (w[15:13] == OPC_CALL)
            r = BCX_OP_CALL;
        else if (w[15:11] == OPC_SKIP_BIT)
            r = BCX_OP_SKIP_BIT;
        else if (w[15:11] == OPC_TOGGLE)
            r = BCX_OP_TOGGLE;
        else if (w[15:9] == OPC_CLEAR)
            r = BCX_OP_CLEAR;
        else if (w[15:9] == OPC_COMP)
            r = BCX_OP_COMP;
        else if (w[15:8] == OPC_SKIP_EQ)
            r = BCX_OP_SKIP_EQ;
        else if (w[15:8] == OPC_SKIP_GT)
            r = BCX_OP_SKIP_GT;
        else if (w == OPC_WDOG_CLR)
            r = BCX_OP_WDOG_CLR;
        return r;
    endfunction

    logic [15:0] ir;
    logic [7:0]  opnd;
    logic [7:0]  result;
    logic        wr_mem;
    logic        wr_work;
    logic        skip_pend;
    logic        forced_nop;
    logic        exec_en;
    bcx_op_t     op;
    logic        active;
    logic [2:0]  bit_sel;
    logic        bit_val;
    logic        eq_hit;
    logic        gt_hit;
    logic        uses_mem;
    logic        apb_wr;
    logic [8:0]  cmp_diff;

    assign op       = bcx_decode(ir);
    assign active   = exec_en && !forced_nop;
    assign bit_sel  = ir[BIT_SEL_LSB +: 3];
    assign bit_val  = opnd[bit_sel];
    // difference is only looked at, never stored
    assign cmp_diff = {1'b0, opnd} - {1'b0, working_reg};
    assign eq_hit   = (cmp_diff == 9'h000);
    assign gt_hit   = !cmp_diff[8] && !eq_hit;
    assign uses_mem = (op == BCX_OP_SKIP_BIT) || (op == BCX_OP_TOGGLE) || (op == BCX_OP_CLEAR) ||
                      (op == BCX_OP_COMP) || (op == BCX_OP_SKIP_EQ) || (op == BCX_OP_SKIP_GT);

    // quarter phase counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            phase <= BCX_Q1;
        else if (clk_en)
            phase <= bcx_phase_t'(phase + 2'h1);
    end

    // instruction latch, taken at the close of Q1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ir <= 16'h0000;
        else if (clk_en && phase == BCX_Q1)
            ir <= instr_word;
    end

    // operand read in Q2; the memory answers in the same clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            opnd <= 8'h00;
        else if (clk_en && phase == BCX_Q2)
            opnd <= dmem_rdata;
    end

    assign dmem.rd    = (phase == BCX_Q2) && active && uses_mem;
    assign dmem.wr    = (phase == BCX_Q4) && wr_mem;
    assign dmem.addr  = ir[7:0];
    assign dmem.wdata = result;

    // execute in Q3: result and destinations
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result  <= 8'h00;
            wr_mem  <= 1'b0;
            wr_work <= 1'b0;
        end else if (clk_en && phase == BCX_Q3) begin
            result  <= 8'h00;
            wr_mem  <= 1'b0;
            wr_work <= 1'b0;
            if (active) begin
                unique case (op)
                    BCX_OP_TOGGLE: begin
                        result <= opnd ^ (8'h01 << bit_sel);
                        wr_mem <= 1'b1;
                    end
                    BCX_OP_CLEAR: begin
                        result  <= 8'h00;
                        wr_mem  <= 1'b1;
                        wr_work <= !ir[DEST_BIT];
                    end
                    BCX_OP_COMP: begin
                        result  <= ~opnd;
                        wr_mem  <= ir[DEST_BIT];
                        wr_work <= !ir[DEST_BIT];
                    end
                    default: begin
                        result <= 8'h00;
                    end
                endcase
            end
        end else if (clk_en && phase == BCX_Q4) begin
            wr_mem  <= 1'b0;
            wr_work <= 1'b0;
        end
    end

    // skip decision at the close of Q3, from the Q2 operand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            skip_pend <= 1'b0;
        else if (clk_en && phase == BCX_Q3)
            skip_pend <= active && ((op == BCX_OP_SKIP_BIT && bit_val) ||
                                    (op == BCX_OP_SKIP_EQ && eq_hit) ||
                                    (op == BCX_OP_SKIP_GT && gt_hit) ||
                                    op == BCX_OP_CALL);
        else if (clk_en && phase == BCX_Q4)
            skip_pend <= 1'b0;
    end

    // the fetch drops its prefetched word while this is high
    assign squash_fetch = skip_pend && (phase == BCX_Q4);

    // following cycle runs as a forced no-operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            forced_nop <= 1'b0;
        else if (clk_en && phase == BCX_Q4)
            forced_nop <= skip_pend;
    end

    // call: push, load and latch at the close of Q3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_req        <= '0;
            pc_high_latch <= RST_PC_HIGH;
        end else if (clk_en) begin
            pc_req <= '0;
            if (phase == BCX_Q3 && active && op == BCX_OP_CALL) begin
                pc_req.push     <= 1'b1;
                pc_req.ret_addr <= pc_cur + 16'h0001;
                pc_req.load     <= 1'b1;
                pc_req.target   <= {pc_cur[15:13], ir[CALL_LIT_MSB:0]};
                pc_high_latch   <= {pc_cur[15:13], ir[CALL_LIT_MSB:8]};
            end
        end
    end

    // watchdog clear strobes, both in Q4 of the same instruction
    assign wdt_clr      = (phase == BCX_Q4) && active && (op == BCX_OP_WDOG_CLR);
    assign wdt_post_clr = wdt_clr;

    // clear watchdog outranks a same-cycle timeout or sleep event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag_n   <= RST_FLAG_N;
            powerdown_flag_n <= RST_FLAG_N;
        end else if (clk_en) begin
            if (wdt_clr) begin
                timeout_flag_n   <= 1'b1;
                powerdown_flag_n <= 1'b1;
            end else begin
                if (wdt_timeout_evt)
                    timeout_flag_n <= 1'b0;
                if (sleep_evt)
                    powerdown_flag_n <= 1'b0;
            end
        end
    end

    // zero flag: only complement touches it here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            zero_flag <= 1'b0;
        else if (clk_en && phase == BCX_Q4 && active && op == BCX_OP_COMP)
            zero_flag <= (result == 8'h00);
    end

    // apb: zero wait states while enabled; frozen core stretches the access
    assign pready  = clk_en;
    assign pslverr = psel && penable &&
                     !(paddr == REG_CTRL || paddr == REG_WORK || paddr == REG_STATUS || paddr == REG_PC_HIGH);
    assign apb_wr  = psel && penable && pwrite && clk_en && !pslverr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            exec_en <= RST_EXEC_EN;
        else if (apb_wr && paddr == REG_CTRL)
            exec_en <= pwdata[0];
    end

    // core write in Q4 has priority over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            working_reg <= RST_WORK;
        else if (clk_en && phase == BCX_Q4 && wr_work)
            working_reg <= result;
        else if (apb_wr && paddr == REG_WORK)
            working_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (clk_en && psel && !penable && !pwrite) begin
            unique case (paddr)
                REG_CTRL:   prdata <= {31'h0, exec_en};
                REG_WORK:   prdata <= {24'h0, working_reg};
                REG_STATUS: prdata <= {28'h0, forced_nop, zero_flag, powerdown_flag_n, timeout_flag_n};
                REG_PC_HIGH: prdata <= {24'h0, pc_high_latch};
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge pclk iff clk_en);
    endclocking
    default disable iff (!presetn);

    chk_skip_bit_set: assert property (
        (phase == BCX_Q3 && active && op == BCX_OP_SKIP_BIT) |=> (skip_pend == $past(bit_val)))
        else $error("bit-set skip decision wrong");

    chk_skip_forces_nop: assert property (
        (phase == BCX_Q4 && skip_pend) |-> squash_fetch ##1 (forced_nop && !dmem.rd)[*4])
        else $error("taken skip did not force a nop cycle");

    chk_toggle_write: assert property (
        (phase == BCX_Q3 && active && op == BCX_OP_TOGGLE)
        |=> dmem.wr && dmem.wdata == ($past(opnd) ^ (8'h01 << $past(bit_sel))))
        else $error("toggle write-back wrong");

    chk_call_push: assert property (
        (phase == BCX_Q3 && active && op == BCX_OP_CALL)
        |=> pc_req.push && pc_req.load && pc_req.ret_addr == $past(pc_cur) + 16'h0001 &&
            pc_req.target[12:0] == $past(ir[12:0]) && pc_req.target[15:13] == $past(pc_cur[15:13]))
        else $error("call push or load wrong");

    chk_call_latch: assert property (
        pc_req.load |-> pc_high_latch == pc_req.target[15:8])
        else $error("pc high latch mismatch after call");

    chk_call_two_cycles: assert property (
        (phase == BCX_Q3 && active && op == BCX_OP_CALL) |=> ##1 forced_nop[*4] ##0 $stable(zero_flag))
        else $error("call second cycle not a forced nop");

    chk_clear_file: assert property (
        (phase == BCX_Q4 && wr_mem && op == BCX_OP_CLEAR)
        |-> dmem.wdata == 8'h00 && (wr_work == !ir[DEST_BIT]) ##1 (!$past(wr_work) || working_reg == 8'h00))
        else $error("clear file destinations wrong");

    chk_wdt_flags: assert property (
        wdt_clr |=> timeout_flag_n && powerdown_flag_n)
        else $error("watchdog clear left a status flag low");

    chk_wdt_post: assert property (
        (phase == BCX_Q3 && active && op == BCX_OP_WDOG_CLR) |=> wdt_clr && wdt_post_clr)
        else $error("postscaler clear missing");

    chk_comp_zero: assert property (
        (phase == BCX_Q4 && active && op == BCX_OP_COMP)
        |=> zero_flag == ($past(result) == 8'h00) && $past(result) == ~$past(opnd))
        else $error("complement result or zero flag wrong");

    chk_cmp_no_flags: assert property (
        (phase == BCX_Q2 && active && (op == BCX_OP_SKIP_EQ || op == BCX_OP_SKIP_GT))
        |=> ($stable(zero_flag) && !dmem.wr && !wr_work)[*3])
        else $error("compare altered state");

    chk_skip_equal: assert property (
        (phase == BCX_Q3 && active && op == BCX_OP_SKIP_EQ) |=> (skip_pend == $past(eq_hit)))
        else $error("equal skip decision wrong");

    chk_skip_greater: assert property (
        (phase == BCX_Q3 && active && op == BCX_OP_SKIP_GT) |=> (skip_pend == ($past(opnd) > $past(working_reg))))
        else $error("greater skip taken when not greater");

    chk_skip_from_q2: assert property (
        (phase == BCX_Q2 && active && op == BCX_OP_SKIP_EQ && dmem_rdata == working_reg) |=> ##1 skip_pend)
        else $error("skip not formed from q2 operand");

endmodule

// ==== sim/tb_bcx_exec.sv ====
module tb_bcx_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import bcx_pkg::*;

    logic             pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0]       paddr, dmem_rdata, pc_high_latch, working_reg;
    logic [31:0]      pwdata, prdata, rd;
    logic [15:0]      instr_word, pc_cur;
    logic             squash_fetch, zero_flag, timeout_flag_n, powerdown_flag_n;
    logic             wdt_timeout_evt, sleep_evt, wdt_clr, wdt_post_clr, err;
    bcx_phase_t       phase;
    bcx_dmem_req_t    dmem;
    bcx_pc_req_t      pc_req, q4_req;
    logic             q2_rd, q4_sq, q4_wr, q4_wc, q4_pc, zf, n_rd, n_wr, sk;
    logic [7:0]       q2_addr, q4_wd, w, f, a;
    logic [12:0]      k;
    logic [15:0]      p;
    logic [1:0]       ph;
    logic [2:0]       b;
    int               fail_count, tests_run, cyc;

    bcx_exec u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_word(instr_word), .pc_cur(pc_cur), .squash_fetch(squash_fetch), .phase(phase), .dmem(dmem),
        .dmem_rdata(dmem_rdata), .pc_req(pc_req), .pc_high_latch(pc_high_latch), .working_reg(working_reg),
        .zero_flag(zero_flag), .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
        .wdt_timeout_evt(wdt_timeout_evt), .sleep_evt(sleep_evt), .wdt_clr(wdt_clr), .wdt_post_clr(wdt_post_clr));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ceiling well above the fewer than a thousand cycles the sequence needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let a write settle before the caller looks at the register
        @(negedge pclk);
    endtask

    // word enters for one Q1, nxt fills the slot after it; returns once that slot's Q4 has closed
    task automatic exec(input logic [15:0] ins, input logic [7:0] fv, input logic [15:0] nxt);
        @(posedge pclk);
        while (phase !== BCX_Q4) @(posedge pclk);
        instr_word <= ins;
        dmem_rdata <= fv;
        zf = zero_flag;
        repeat (2) @(negedge pclk);
        q2_rd = dmem.rd;
        q2_addr = dmem.addr;
        repeat (2) @(negedge pclk);
        q4_sq = squash_fetch;
        q4_wr = dmem.wr;
        q4_wd = dmem.wdata;
        q4_wc = wdt_clr;
        q4_pc = wdt_post_clr;
        q4_req = pc_req;
        @(posedge pclk);
        instr_word <= nxt;
        @(posedge pclk);
        instr_word <= 16'h0000;
        @(negedge pclk);
        n_rd = dmem.rd;
        repeat (2) @(negedge pclk);
        n_wr = dmem.wr;
        @(negedge pclk);
    endtask

    // the slot after a taken skip or call is squashed; otherwise the clear word in it runs
    task automatic check_slot(input logic taken, input logic [7:0] w_keep);
        check("slot_rd", !taken, n_rd);
        check("slot_wr", !taken, n_wr);
        check("slot_w", taken ? w_keep : 8'h00, working_reg);
    endtask

    function automatic logic exp_skip(input int op, input logic [7:0] fv, wv, input logic [2:0] bs);
        case (op)
            0: return fv == wv;
            1: return fv > wv;
            default: return fv[bs];
        endcase
    endfunction

    initial begin
        {psel, penable, pwrite, paddr, pwdata, wdt_timeout_evt, sleep_evt} = '0;
        instr_word = 16'h0000;
        pc_cur = 16'h0000;
        dmem_rdata = 8'h00;
        clk_en = 1'b1;
        presetn = 1'b0;
        cyc = 0;
        fail_count = 0;
        tests_run = 0;
        void'($urandom(32'h376D));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check("rst_w", 8'h00, working_reg);
        check("rst_pch", 8'h00, pc_high_latch);
        check("rst_flags", 2'b11, {timeout_flag_n, powerdown_flag_n});
        apb(1'b0, REG_CTRL, 0);
        check("ctrl", 1, rd[0]);
        apb(1'b0, 8'h10, 0);
        check("unmapped_err", 1, err);
        $display("test reset_apb done");

        for (int i = 0; i < 24; i++) begin
            w = 8'($urandom);
            a = 8'($urandom);
            b = 3'($urandom);
            case (i % 4)
                0: f = w;
                1: f = w + 8'h01;
                2: f = w - 8'h01;
                default: f = 8'($urandom);
            endcase
            if (i == 3) begin
                w = 8'hFF;
                f = 8'h00;
            end
            sk = exp_skip(i % 3, f, w, b);
            apb(1'b1, REG_WORK, {24'h0, w});
            check("w_write", w, working_reg);
            case (i % 3)
                0: exec({8'h31, a}, f, 16'h2800);
                1: exec({8'h32, a}, f, 16'h2800);
                default: exec({5'h12, b, a}, f, 16'h2800);
            endcase
            check("cmp_rd", {1'b1, a}, {q2_rd, q2_addr});
            check("cmp_sq", sk, q4_sq);
            check("cmp_nowr", 0, q4_wr);
            check("cmp_zf", zf, zero_flag);
            check_slot(sk, w);
        end
        $display("test skips done");

        for (int i = 0; i < 8; i++) begin
            f = 8'($urandom);
            a = 8'($urandom);
            b = 3'(i);
            exec({5'h07, b, a}, f, 16'h0000);
            check("tog", {2'b10, f ^ (8'h01 << b)}, {q4_wr, q4_sq, q4_wd});
            check("tog_zf", zf, zero_flag);
        end
        $display("test toggle done");

        exec(16'h13FF, 8'hFF, 16'h0000);
        check("complement_file_op_f", {1'b1, 8'h00}, {q4_wr, q4_wd});
        check("complement_file_op_z", 1, zero_flag);
        exec(16'h1200, 8'h3C, 16'h0000);
        check("complement_file_op_w", {1'b0, 8'hC3}, {q4_wr, working_reg});
        check("complement_file_op_nz", 0, zero_flag);
        exec(16'h2955, 8'h77, 16'h0000);
        check("clr1", {1'b1, 8'h00, 8'hC3}, {q4_wr, q4_wd, working_reg});
        exec(16'h28AA, 8'h77, 16'h0000);
        check("clr0", {1'b1, 8'h00, 8'h00}, {q4_wr, q4_wd, working_reg});
        $display("test clear_comp done");

        for (int i = 0; i < 4; i++) begin
            k = 13'($urandom);
            p = 16'($urandom);
            w = 8'($urandom) | 8'h01;
            if (i == 0) p = 16'hFFFF;
            apb(1'b1, REG_WORK, {24'h0, w});
            @(posedge pclk);
            pc_cur <= p;
            exec({3'h7, k}, 8'h00, 16'h2800);
            check("call_push", {1'b1, p + 16'h0001}, {q4_req.push, q4_req.ret_addr});
            check("call_load", {1'b1, p[15:13], k}, {q4_req.load, q4_req.target});
            check("call_latch", {p[15:13], k[12:8]}, pc_high_latch);
            check("call_sq", 1, q4_sq);
            check_slot(1'b1, w);
            check("call_zf", zf, zero_flag);
            apb(1'b0, REG_PC_HIGH, 0);
            check("pch_read", {p[15:13], k[12:8]}, rd);
        end
        $display("test call done");

        // with the enable low nothing may move and the bus must stall
        @(posedge pclk);
        clk_en <= 1'b0;
        @(negedge pclk);
        ph = phase;
        repeat (4) @(negedge pclk);
        check("frz_phase", ph, phase);
        check("frz_ready", 0, pready);
        @(posedge pclk);
        clk_en <= 1'b1;
        $display("test freeze done");

        @(posedge pclk);
        wdt_timeout_evt <= 1'b1;
        sleep_evt <= 1'b1;
        @(posedge pclk);
        wdt_timeout_evt <= 1'b0;
        sleep_evt <= 1'b0;
        apb(1'b0, REG_STATUS, 0);
        check("evt_flags", 2'b00, rd[1:0]);
        exec(16'h0004, 8'h00, 16'h0000);
        check("wdt_clr", 2'b11, {q4_wc, q4_pc});
        check("wdt_flags", 2'b11, {timeout_flag_n, powerdown_flag_n});
        apb(1'b0, REG_STATUS, 0);
        check("wdt_status", 2'b11, rd[1:0]);
        $display("test watchdog done");
        print_verdict();
    end
endmodule
